// ---- rtl/pzc_match.sv ----
// Combinational zone search over the whole table.
// Assumes the caller registers the result; no state is kept here.
`timescale 1ns/1ps
module pzc_match (
	input  pzc_pkg::pzc_pos_t   position,
	input  pzc_pkg::pzc_table_t table_w,
	output pzc_pkg::pzc_code_t  code,
	output logic                hit
);
	import pzc_pkg::*;

	// Scanning from the top down lets the lowest matching number win.
	always_comb begin
		code = PZC_CODE_OFF;
		hit  = 1'b0;
		for (int i = PZC_ZONES - 1; i >= 0; i--) begin
			if (pzc_in_zone(position, table_w[i])) begin // see (RULE_06)
				code = pzc_code_t'(i);
				hit  = 1'b1;
			end
		end
	end

endmodule : pzc_match

// ---- rtl/pzc_pkg.sv ----
// Package for the position zone comparator: types, limits and reset values.
// Assumes a single core clock and a signed 32-bit position from the drive.
package pzc_pkg;

	localparam int unsigned PZC_ZONES     = 8;
	localparam int unsigned PZC_CODE_W    = 3;
	localparam int unsigned PZC_POS_W     = 32;

	typedef logic signed [PZC_POS_W-1:0]  pzc_pos_t;
	typedef logic        [PZC_CODE_W-1:0] pzc_code_t;

	localparam pzc_pos_t  PZC_POS_MAX     = 32'sh3FFF_FFFF;
	localparam pzc_pos_t  PZC_POS_MIN     = 32'shC000_0001;
	localparam pzc_pos_t  PZC_BOUND_RST   = 32'sh0000_0000;
	localparam pzc_code_t PZC_CODE_OFF    = 3'h0;
	localparam logic      PZC_INIT_OFF    = 1'h0;
	localparam logic      PZC_INIT_ZONE   = 1'h1;

	typedef struct packed {
		pzc_pos_t lower;
		pzc_pos_t upper;
	} pzc_bounds_t;

	typedef pzc_bounds_t [PZC_ZONES-1:0] pzc_table_t;

	typedef struct packed {
		logic        en;
		pzc_code_t   idx;
		pzc_bounds_t bounds;
	} pzc_tbl_wr_t;

	typedef struct packed {
		pzc_table_t table_w;
		logic       init_sel;
		pzc_code_t  code;
		logic       hit;
	} pzc_state_t;

	// Bounds outside the legal span are pulled to the nearest limit.
	function automatic pzc_pos_t pzc_clamp(input pzc_pos_t v);
		pzc_pos_t r;
		r = v;
		if (v > PZC_POS_MAX) begin
			r = PZC_POS_MAX;
		end else if (v < PZC_POS_MIN) begin
			r = PZC_POS_MIN;
		end
		return r;
	endfunction : pzc_clamp

	function automatic logic pzc_disabled(input pzc_bounds_t b);
		return (b.lower == PZC_BOUND_RST) && (b.upper == PZC_BOUND_RST);
	endfunction : pzc_disabled

	// Normal span when lower <= upper, wrapped span when upper < lower.
	function automatic logic pzc_in_zone(input pzc_pos_t p, input pzc_bounds_t b);
		logic r;
		r = 1'b0;
		if (pzc_disabled(b)) begin
			r = 1'b0; // see (RULE_07)
		end else if (b.lower <= b.upper) begin
			r = (p >= b.lower) && (p <= b.upper); // see (RULE_04)
		end else begin
			r = (p <= b.upper) || (p >= b.lower); // see (RULE_05)
		end
		return r;
	endfunction : pzc_in_zone

endpackage : pzc_pkg

// ---- rtl/pzc_top.sv ----
// Position zone comparator: zone table, flash copy and registered zone code outputs.
// Assumes position, table writes and save requests are synchronous to CORE_CLK.
//
// Behaviour
// (RULE_01) The table holds eight entries, numbered zero to seven, each with a lower and upper bound.
// (RULE_02) Bounds are signed, limited to plus or minus 1073741823, reset to 0, and act at once.
// (RULE_03) A position inside a zone drives that zone number in binary, bit 0 lowest, 1 active.
// (RULE_04) With lower not above upper, the zone covers lower to upper with both ends included.
// (RULE_05) With upper below lower, the zone covers up to upper and from lower upward.
// (RULE_06) When several entries match, the lowest zone number is output.
// (RULE_07) An entry with both bounds zero is disabled and never matches.
// (RULE_08) With no matching entry all three output lines are inactive.
// (RULE_09) Code bits zero, one and two drive programmable output lines zero, one and two.
// (RULE_10) Table edits are volatile and are lost at reset unless saved to the flash copy first.
// (RULE_11) A select sampled at reset keeps the outputs off when zero or shows the code when one; ZONE_HIT still shows a match when zero.
// (RULE_12) All entries are compared every cycle and the code is registered before the pins.
`timescale 1ns/1ps
module pzc_top (
	input  wire logic                CORE_CLK,
	input  wire logic                RST_N,
	input  wire logic                CLK_EN,
	input  wire pzc_pkg::pzc_pos_t   CUR_POSITION,
	input  wire pzc_pkg::pzc_tbl_wr_t TBL_WR,
	input  wire logic                SAVE_REQ,
	input  wire logic                FLASH_INIT,
	input  wire logic                ZONE_INIT_SELECT,
	output logic [2:0]               PROG_OUTPUT_LINE,
	output logic                     ZONE_HIT
);
	import pzc_pkg::*;

	pzc_state_t  state_q;
	pzc_state_t  state_d;
	pzc_code_t   match_code;
	logic        match_hit;
	pzc_table_t  flash_view;
	pzc_bounds_t wr_bounds;
	logic        after_rst_q;
	logic        lower_hit;
	pzc_bounds_t chosen;

	// Flash copy survives RST_N, so it carries no reset; it starts erased.
	pzc_bounds_t flash_mem [PZC_ZONES] = '{default: '0};

	pzc_match u_match (
		.position (CUR_POSITION),
		.table_w  (state_q.table_w),
		.code     (match_code),
		.hit      (match_hit)
	);

	always_comb begin
		for (int i = 0; i < PZC_ZONES; i++) begin
			flash_view[i] = flash_mem[i];
		end
	end

	always_comb begin
		wr_bounds.lower = pzc_clamp(TBL_WR.bounds.lower); // see (RULE_02)
		wr_bounds.upper = pzc_clamp(TBL_WR.bounds.upper); // see (RULE_02)
	end

	always_comb begin
		state_d = state_q;
		if (!RST_N) begin
			state_d.table_w  = flash_view; // see (RULE_10)
			state_d.init_sel = ZONE_INIT_SELECT; // see (RULE_11)
			state_d.code     = PZC_CODE_OFF;
			state_d.hit      = 1'b0;
		end else if (CLK_EN) begin
			if (TBL_WR.en) begin
				state_d.table_w[TBL_WR.idx] = wr_bounds; // see (RULE_01)
			end
			state_d.hit = match_hit; // see (RULE_12)
			if (state_q.init_sel == PZC_INIT_ZONE && match_hit) begin
				state_d.code = match_code; // see (RULE_03)
			end else begin
				state_d.code = PZC_CODE_OFF; // see (RULE_08) (RULE_11)
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		state_q <= state_d;
	end

	// Initialise wins over save; both wait for reset release so a restore is clean.
	always_ff @(posedge CORE_CLK) begin
		if (RST_N && CLK_EN) begin
			for (int i = 0; i < PZC_ZONES; i++) begin
				if (FLASH_INIT) begin
					flash_mem[i] <= '0;
				end else if (SAVE_REQ) begin
					flash_mem[i] <= state_q.table_w[i]; // see (RULE_10)
				end
			end
		end
	end

	always_comb begin
		PROG_OUTPUT_LINE[0] = state_q.code[0]; // see (RULE_09)
		PROG_OUTPUT_LINE[1] = state_q.code[1]; // see (RULE_09)
		PROG_OUTPUT_LINE[2] = state_q.code[2]; // see (RULE_09)
		ZONE_HIT            = state_q.hit;
	end

	// Helper logic read only by the checks below.
	always_ff @(posedge CORE_CLK) begin
		after_rst_q <= !RST_N;
	end

	always_comb begin
		chosen    = state_q.table_w[match_code];
		lower_hit = 1'b0;
		for (int i = 0; i < PZC_ZONES; i++) begin
			if (pzc_code_t'(i) < match_code && pzc_in_zone(CUR_POSITION, state_q.table_w[i])) begin
				lower_hit = 1'b1;
			end
		end
	end

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);

	a_out_tracks_match: assert property ( // see (RULE_12) (RULE_03)
		CLK_EN && state_q.init_sel && match_hit |=> PROG_OUTPUT_LINE == $past(match_code)
	) else $error("zone code not registered one cycle after match");

	a_out_idle_nomatch: assert property ( // see (RULE_08)
		CLK_EN && !match_hit |=> PROG_OUTPUT_LINE == 3'h0 && !ZONE_HIT
	) else $error("outputs active with no matching zone");

	a_init_off_hold: assert property ( // see (RULE_11)
		state_q.init_sel == PZC_INIT_OFF |-> PROG_OUTPUT_LINE == 3'h0
	) else $error("outputs active while start select is off");

	a_init_sel_caught: assert property ( // see (RULE_11)
		after_rst_q |-> state_q.init_sel == $past(ZONE_INIT_SELECT)
	) else $error("start select not captured at reset");

	a_disabled_no_hit: assert property ( // see (RULE_07)
		match_hit |-> !pzc_disabled(chosen)
	) else $error("disabled entry produced a match");

	a_lowest_wins: assert property ( // see (RULE_06)
		match_hit |-> !lower_hit
	) else $error("a lower zone number also matched");

	a_span_normal: assert property ( // see (RULE_04)
		match_hit && chosen.lower <= chosen.upper |->
			CUR_POSITION >= chosen.lower && CUR_POSITION <= chosen.upper
	) else $error("match outside normal span");

	a_span_wrapped: assert property ( // see (RULE_05)
		match_hit && chosen.upper < chosen.lower |->
			CUR_POSITION <= chosen.upper || CUR_POSITION >= chosen.lower
	) else $error("match outside wrapped span");

	a_write_applies: assert property ( // see (RULE_02)
		CLK_EN && TBL_WR.en |=> state_q.table_w[$past(TBL_WR.idx)] == $past(wr_bounds)
	) else $error("table write did not take effect next cycle");

	a_bounds_in_range: assert property ( // see (RULE_02)
		CLK_EN && TBL_WR.en |=> state_q.table_w[$past(TBL_WR.idx)].lower <= PZC_POS_MAX
			&& state_q.table_w[$past(TBL_WR.idx)].lower >= PZC_POS_MIN
	) else $error("stored bound outside legal span");

	a_reset_restores: assert property ( // see (RULE_10)
		after_rst_q |-> state_q.table_w == flash_view
	) else $error("table not restored from flash copy at reset");

	a_save_copies: assert property ( // see (RULE_10)
		CLK_EN && SAVE_REQ && !FLASH_INIT |=> flash_view == $past(state_q.table_w)
	) else $error("save did not copy the table");

	a_enable_freezes: assert property (
		!CLK_EN |=> $stable(PROG_OUTPUT_LINE) && $stable(state_q.table_w)
	) else $error("state moved while clock enable low");

	// The checks below tie the registered pins back to the live search result and recheck the match, start select, stored table and flash copy.
	// They are kept separate from the span checks so that a failure names the stage at fault.
	a_hit_tracks_match: assert property ( // see (RULE_12)
		CLK_EN |=> ZONE_HIT == $past(match_hit)
	) else $error("zone hit not registered one cycle after search");

	a_match_in_zone: assert property ( // see (RULE_03)
		match_hit |-> pzc_in_zone(CUR_POSITION, chosen)
	) else $error("reported zone does not contain the position");

	a_point_zone: assert property ( // see (RULE_04)
		match_hit && chosen.lower == chosen.upper |-> CUR_POSITION == chosen.lower
	) else $error("single point zone matched another position");

	a_code_needs_hit: assert property ( // see (RULE_08)
		PROG_OUTPUT_LINE != 3'h0 |-> ZONE_HIT
	) else $error("zone code active without a hit");

	a_code_off_reset: assert property ( // see (RULE_11)
		after_rst_q |-> PROG_OUTPUT_LINE == 3'h0 && !ZONE_HIT
	) else $error("outputs active on the first edge after reset");

	a_sel_stable_run: assert property ( // see (RULE_11)
		!after_rst_q |-> $stable(state_q.init_sel)
	) else $error("start select moved outside reset");

	a_upper_in_range: assert property ( // see (RULE_02)
		CLK_EN && TBL_WR.en |=> state_q.table_w[$past(TBL_WR.idx)].upper <= PZC_POS_MAX
			&& state_q.table_w[$past(TBL_WR.idx)].upper >= PZC_POS_MIN
	) else $error("stored upper bound outside legal span");

	a_table_held: assert property ( // see (RULE_01)
		CLK_EN && !TBL_WR.en |=> $stable(state_q.table_w)
	) else $error("table changed without a write");

	// A stray flash update would only show at the next reset, long after its cause.
	a_init_wins_save: assert property ( // see (RULE_10)
		CLK_EN && FLASH_INIT |=> flash_view == '0
	) else $error("flash copy not erased by initialise");

	a_flash_frozen: assert property ( // see (RULE_10)
		!CLK_EN || (!SAVE_REQ && !FLASH_INIT) |=> $stable(flash_view)
	) else $error("flash copy changed without a request");

endmodule : pzc_top

// ---- verification/pzc_host.sv ----
// Host-side reader of the three programmable output lines.
// Assumes the lines are registered levels that settle well before each rising edge.
`timescale 1ns/1ps
module pzc_host (
	input  wire logic       clk,
	input  wire logic [2:0] prog_output_line,
	output logic      [2:0] zone_code
);
	// Line i carries code bit i, so the host reads the code straight across.
	always_ff @(posedge clk) begin
		zone_code <= prog_output_line;
	end
endmodule : pzc_host

// ---- verification/pzc_top_bench.sv ----
// Self-checking bench: random positions and table edits checked against a reference table.
// Assumes pzc_pkg, pzc_top and pzc_host are compiled before this file.
`timescale 1ns/1ps
module pzc_top_bench;
	import pzc_pkg::*;
	logic        clk = 0, rst_n = 0, clk_en = 1, save = 0, finit = 0, sel = 1;
	pzc_pos_t    pos = '0;
	pzc_tbl_wr_t wr = '0;
	logic [2:0]  lines, zc, pl;
	logic        hit;
	logic [3:0]  last = '0;
	pzc_table_t  tbl = '0, fl = '0;
	int          bad_count = 0, n_compared = 0, cyc = 0;
	pzc_pos_t    pa[] = '{10, 20, 21, 9, 15, -100, 100, 0, 101, -101,
		32'sh3FFF_FFFF, 32'sh3FFF_FFFE};

	pzc_top dut (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en), .CUR_POSITION(pos),
		.TBL_WR(wr), .SAVE_REQ(save), .FLASH_INIT(finit), .ZONE_INIT_SELECT(sel),
		.PROG_OUTPUT_LINE(lines), .ZONE_HIT(hit));
	pzc_host host (.clk(clk), .prog_output_line(lines), .zone_code(zc));

	initial begin
		forever #2 clk = ~clk;
	end

	function automatic pzc_pos_t clip(pzc_pos_t v);
		return (v > PZC_POS_MAX) ? PZC_POS_MAX : ((v < PZC_POS_MIN) ? PZC_POS_MIN : v);
	endfunction : clip

	// Scanning downward leaves the lowest matching zone as the answer.
	function automatic logic [3:0] ref_zone(pzc_pos_t p);
		logic [3:0] r;
		pzc_pos_t   l, u;
		r = '0;
		for (int i = 7; i >= 0; i--) begin
			l = tbl[i].lower;
			u = tbl[i].upper;
			if ((l != 0 || u != 0) && ((l <= u) ? (p >= l && p <= u) : (p <= u || p >= l))) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction : ref_zone

	// Small bounds make overlaps likely; a rare full-width value exercises clamping.
	function automatic pzc_pos_t rb();
		return ($urandom_range(15) == 0) ? $signed($urandom) : pzc_pos_t'($urandom_range(96)) - 48;
	endfunction : rb

	task automatic cmp(logic [3:0] got, logic [3:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic st(pzc_pos_t p, logic we = 0, logic [2:0] ix = 0, pzc_pos_t l = 0,
		pzc_pos_t u = 0, logic en = 1, logic sv = 0, logic fi = 0);
		logic [3:0] e;
		e = ref_zone(p);
		pl = last[2:0];
		pos = p;
		wr = '{we, ix, '{l, u}};
		clk_en = en;
		save = sv;
		finit = fi;
		@(negedge clk);
		if (en) begin
			last = {e[3], sel ? e[2:0] : 3'h0};
			if (fi) begin
				fl = '0;
			end else if (sv) begin
				fl = tbl;
			end
			if (we) begin
				tbl[ix] = '{clip(l), clip(u)};
			end
		end
		cmp({hit, lines}, last);
		cmp({1'b0, zc}, {1'b0, pl});
	endtask : st

	task automatic rst(logic s);
		rst_n = 0;
		sel = s;
		repeat (8) @(negedge clk);
		cmp({hit, lines}, 4'h0);
		tbl = fl;
		last = 4'h0;
		rst_n = 1;
	endtask : rst

	task automatic rnd(int n);
		repeat (n) begin
			st(rb(), $urandom_range(3) == 0, 3'($urandom_range(7)), rb(), rb(),
				$urandom_range(7) != 0, $urandom_range(31) == 0);
		end
	endtask : rnd

	task automatic complete_run();
		if (bad_count == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end

	initial begin
		void'($urandom(43));
		rst(1);
		st(5);
		st(0, 1, 3, 10, 20);
		st(0, 1, 1, 15, 15);
		st(0, 1, 5, 100, -100);
		st(0, 1, 6, 32'sh7000_0000, 32'sh7FFF_FFFF);
		foreach (pa[i]) begin
			st(pa[i]);
		end
		rnd(3000);
		st(0, 1, 4, -5, 5, 1, 1);
		st(0, 0, 0, 0, 0, 1, 1);
		st(0, 1, 4, 7, 8);
		rst(1);
		rnd(300);
		rst(0);
		rnd(300);
		st(0, 0, 0, 0, 0, 1, 1, 1);
		rst(1);
		rnd(50);
		complete_run();
	end
endmodule : pzc_top_bench
